/* File: shared/tpq_pkg.sv */
package tpq_pkg;
    // geometry of the packet buffer
    localparam int NPKT      = 8;
    localparam int PNR_W     = 3;
    localparam int PWORDS    = 64;
    localparam int PTR_W     = 6;
    localparam int DW        = 16;
    localparam int CAP_BYTES = PWORDS * 2;

    // status word layout and reset values
    localparam int              ST_OK_BIT  = 0;
    localparam logic [PTR_W-1:0] PTR_FIRST = 6'h00;
    localparam logic            TX_EN_RST  = 1'b0;

    // host commands
    typedef enum logic [3:0] {
        OP_NOP     = 4'h0,
        OP_ALLOC   = 4'h1,
        OP_SET_PNR = 4'h2,
        OP_SET_PTR = 4'h3,
        OP_WR_DATA = 4'h4,
        OP_RD_DATA = 4'h5,
        OP_ENQ     = 4'h6,
        OP_RELEASE = 4'h7,
        OP_TX_ACK  = 4'h8,
        OP_TX_EN   = 4'h9,
        OP_CLR_EVT = 4'ha
    } tpq_op_t;

    // device transmit sequencer
    typedef enum logic [1:0] {
        D_IDLE = 2'h1,
        D_XMIT = 2'h2
    } tpq_dst_t;

    // host driver sequencer
    typedef enum logic [14:0] {
        H_INIT = 15'h0001,
        H_IDLE = 15'h0002,
        H_WAIT = 15'h0004,
        H_PTR  = 15'h0008,
        H_DATA = 15'h0010,
        H_ENQ  = 15'h0020,
        H_SPNR = 15'h0040,
        H_SPTR = 15'h0080,
        H_SRD  = 15'h0100,
        H_SWT  = 15'h0200,
        H_SREL = 15'h0400,
        H_SACK = 15'h0800,
        H_FAIL = 15'h1000,
        H_FDEC = 15'h2000,
        H_FCLR = 15'h4000
    } tpq_hst_t;
endpackage

/* File: shared/tpq_if.sv */
`timescale 1ns/100ps
interface tpq_if;
    logic                      cmd_vld;
    tpq_pkg::tpq_op_t          cmd_op;
    logic [tpq_pkg::DW-1:0]    cmd_arg;
    logic                      alloc_done;
    logic [tpq_pkg::PNR_W-1:0] alloc_pnr;
    logic                      rd_vld;
    logic [tpq_pkg::DW-1:0]    rd_data;
    logic                      tx_en;
    logic                      tx_int;
    logic                      tx_evt;
    logic [tpq_pkg::PNR_W-1:0] port_pnr;
    logic                      port_empty;
    logic [tpq_pkg::DW-1:0]    ph_status;

    modport dev (
        input  cmd_vld, cmd_op, cmd_arg,
        output alloc_done, alloc_pnr, rd_vld, rd_data, tx_en,
        output tx_int, tx_evt, port_pnr, port_empty, ph_status
    );
    modport host (
        output cmd_vld, cmd_op, cmd_arg,
        input  alloc_done, alloc_pnr, rd_vld, rd_data, tx_en,
        input  tx_int, tx_evt, port_pnr, port_empty, ph_status
    );
endinterface

/* File: logic/tpq_fifo.sv */
`timescale 1ns/100ps
module tpq_fifo #(
    parameter int W     = 3,
    parameter int DEPTH = 8
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst_n,
    input  wire logic         i_push,
    input  wire logic [W-1:0] i_din,
    input  wire logic         i_pop,
    output logic [W-1:0]      o_dout,
    output logic              o_full,
    output logic              o_empty
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0]   cnt_reg;
    logic          do_push;
    logic          do_pop;

    // push into a full fifo or pop from an empty one is ignored
    assign do_push = i_push && !o_full;
    assign do_pop  = i_pop && !o_empty;
    assign o_full  = (cnt_reg == (AW+1)'(DEPTH));
    assign o_empty = (cnt_reg == '0);
    assign o_dout  = mem_reg[rd_reg];

    // storage, written in arrival order
    always_ff @(posedge i_clk_sys) begin
        if (do_push) begin
            mem_reg[wr_reg] <= i_din;
        end
    end

    // pointers and fill level
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (do_push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
            if (do_push && !do_pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (do_pop && !do_push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule

/* File: logic/tpq_dev.sv */
// Operation
// - allocate command reserves N bytes of buffer
// - allocation done flag set on success
// - assigned number shown in allocation result
// - host loads number, pointer, then frame data
// - enqueue pushes packet number register value
// - send only with enable, after deferral in half duplex
// - status word overwrites packet's first word
// - completion moves number to completion fifo
// - interrupt while completion fifo not empty
// - failure sets event, clears enable, stops
// - failed number shown in fifo port
// - host reads port, reloads packet number
// - status word readable through buffer path
// - release command frees packet buffer memory
// - acknowledge write pops completion fifo head
// - host releases or retries failed packet
// - auto free releases pages at completion
`timescale 1ns/100ps
module tpq_dev (
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_rst_n,
    tpq_if.dev                             bus,
    input  wire logic                      i_auto_release,
    input  wire logic                      i_half_duplex,
    input  wire logic                      i_defer_ok,
    output logic                           o_mac_start,
    output logic [tpq_pkg::PNR_W-1:0]      o_mac_pnr,
    input  wire logic [tpq_pkg::PTR_W-1:0] i_mac_rd_addr,
    output logic [tpq_pkg::DW-1:0]         o_mac_rd_data,
    input  wire logic                      i_mac_done,
    input  wire logic                      i_mac_ok,
    input  wire logic [tpq_pkg::DW-1:0]    i_mac_status
);
    localparam int PW = tpq_pkg::PNR_W;
    localparam int TW = tpq_pkg::PTR_W;
    localparam int DW = tpq_pkg::DW;

    logic [DW-1:0]           mem_reg [tpq_pkg::NPKT*tpq_pkg::PWORDS];
    logic [PW-1:0]           pnr_reg;
    logic [TW-1:0]           ptr_reg;
    logic                    tx_en_reg;
    logic                    evt_reg;
    logic                    done_reg;
    logic                    pend_reg;
    logic [PW-1:0]           apnr_reg;
    logic [tpq_pkg::NPKT-1:0] busy_reg;
    logic [DW-1:0]           rd_data_reg;
    logic                    rd_vld_reg;
    logic [PW-1:0]           xpnr_reg;
    logic [PW-1:0]           fpnr_reg;
    logic [PW-1:0]           port_reg;
    logic                    port_empty_reg;
    logic [DW-1:0]           ph_reg;
    logic                    start_reg;
    logic [DW-1:0]           mrd_reg;
    tpq_pkg::tpq_dst_t       st_reg;

    logic          op_alloc;
    logic          op_wr;
    logic          op_rd;
    logic          op_enq;
    logic          op_rel;
    logic          op_ack;
    logic          free_any;
    logic [PW-1:0] free_idx;
    logic          grant;
    logic          go;
    logic          fin;
    logic          fin_ok;
    logic          fin_bad;
    logic [PW-1:0] txq_head;
    logic          txq_empty;
    logic          txq_full;
    logic [PW-1:0] cq_head;
    logic          cq_empty;
    logic          cq_full;
    logic [DW-1:0] stat_word;

    // command decode
    assign op_alloc = bus.cmd_vld && bus.cmd_op == tpq_pkg::OP_ALLOC;
    assign op_wr    = bus.cmd_vld && bus.cmd_op == tpq_pkg::OP_WR_DATA;
    assign op_rd    = bus.cmd_vld && bus.cmd_op == tpq_pkg::OP_RD_DATA;
    assign op_enq   = bus.cmd_vld && bus.cmd_op == tpq_pkg::OP_ENQ;
    assign op_rel   = bus.cmd_vld && bus.cmd_op == tpq_pkg::OP_RELEASE;
    assign op_ack   = bus.cmd_vld && bus.cmd_op == tpq_pkg::OP_TX_ACK;

    // lowest free packet number
    always_comb begin
        free_any = 1'b0;
        free_idx = '0;
        for (int i = tpq_pkg::NPKT - 1; i >= 0; i--) begin
            if (!busy_reg[i]) begin
                free_any = 1'b1;
                free_idx = PW'(i);
            end
        end
    end

    // an oversize request is never granted; a deferred one retries
    assign grant = ((op_alloc && bus.cmd_arg <= DW'(tpq_pkg::CAP_BYTES))
                    || pend_reg) && free_any;

    // allocation result and done flag
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            done_reg <= 1'b0;
            pend_reg <= 1'b0;
            apnr_reg <= '0;
        end else begin
            if (op_alloc) begin
                done_reg <= 1'b0;
                pend_reg <= bus.cmd_arg <= DW'(tpq_pkg::CAP_BYTES);
            end
            if (grant) begin
                done_reg <= 1'b1;
                pend_reg <= 1'b0;
                apnr_reg <= free_idx;
            end
        end
    end

    // page ownership: allocate, release, automatic free
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            busy_reg <= '0;
        end else begin
            if (op_rel) begin
                busy_reg[bus.cmd_arg[PW-1:0]] <= 1'b0;
            end
            if (fin_ok && i_auto_release) begin
                busy_reg[xpnr_reg] <= 1'b0;
            end
            if (grant) begin
                busy_reg[free_idx] <= 1'b1;
            end
        end
    end

    // packet number and pointer registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            pnr_reg <= '0;
            ptr_reg <= tpq_pkg::PTR_FIRST;
        end else begin
            if (bus.cmd_vld && bus.cmd_op == tpq_pkg::OP_SET_PNR) begin
                pnr_reg <= bus.cmd_arg[PW-1:0];
            end
            if (bus.cmd_vld && bus.cmd_op == tpq_pkg::OP_SET_PTR) begin
                ptr_reg <= bus.cmd_arg[TW-1:0];
            end else if (op_wr || op_rd) begin
                ptr_reg <= ptr_reg + 1'b1; // auto increment
            end
        end
    end

    // status word, with the outcome in its ok bit
    always_comb begin
        stat_word = i_mac_status;
        stat_word[tpq_pkg::ST_OK_BIT] = i_mac_ok;
    end

    // buffer memory: host data, status overwrite, two read ports
    always_ff @(posedge i_clk_sys) begin
        if (op_wr) begin
            mem_reg[{pnr_reg, ptr_reg}] <= bus.cmd_arg;
        end
        if (fin) begin
            mem_reg[{xpnr_reg, tpq_pkg::PTR_FIRST}] <= stat_word;
        end
        rd_data_reg <= mem_reg[{pnr_reg, ptr_reg}];
        mrd_reg     <= mem_reg[{xpnr_reg, i_mac_rd_addr}];
    end

    // read strobe for the host data path
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rd_vld_reg <= 1'b0;
        end else begin
            rd_vld_reg <= op_rd;
        end
    end

    // queued numbers and completed numbers
    tpq_fifo #(
        .W     (PW),
        .DEPTH (tpq_pkg::NPKT)
    ) u_txq (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_push    (op_enq),
        .i_din     (pnr_reg),
        .i_pop     (fin),
        .o_dout    (txq_head),
        .o_full    (txq_full),
        .o_empty   (txq_empty)
    );

    tpq_fifo #(
        .W     (PW),
        .DEPTH (tpq_pkg::NPKT)
    ) u_cq (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_push    (fin_ok),
        .i_din     (xpnr_reg),
        .i_pop     (op_ack),
        .o_dout    (cq_head),
        .o_full    (cq_full),
        .o_empty   (cq_empty)
    );

    // launch only when enabled and, in half duplex, after deferral
    assign go = st_reg == tpq_pkg::D_IDLE && tx_en_reg && !txq_empty
                && (!i_half_duplex || i_defer_ok);
    assign fin     = st_reg == tpq_pkg::D_XMIT && i_mac_done;
    assign fin_ok  = fin && i_mac_ok;
    assign fin_bad = fin && !i_mac_ok;

    // transmit sequencer
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            st_reg    <= tpq_pkg::D_IDLE;
            start_reg <= 1'b0;
            xpnr_reg  <= '0;
        end else begin
            start_reg <= 1'b0;
            case (st_reg)
                tpq_pkg::D_IDLE: begin
                    if (go) begin
                        start_reg <= 1'b1;
                        xpnr_reg  <= txq_head;
                        st_reg    <= tpq_pkg::D_XMIT;
                    end
                end
                tpq_pkg::D_XMIT: begin
                    if (i_mac_done) begin
                        st_reg <= tpq_pkg::D_IDLE;
                    end
                end
                default: begin
                    st_reg <= tpq_pkg::D_IDLE;
                end
            endcase
        end
    end

    // transmit enable: failure clears it and beats a host set
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            tx_en_reg <= tpq_pkg::TX_EN_RST;
        end else if (fin_bad) begin
            tx_en_reg <= 1'b0;
        end else if (bus.cmd_vld && bus.cmd_op == tpq_pkg::OP_TX_EN) begin
            tx_en_reg <= bus.cmd_arg[0];
        end
    end

    // transmit event flag and failed number; a new failure beats clear
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            evt_reg  <= 1'b0;
            fpnr_reg <= '0;
            ph_reg   <= '0;
        end else begin
            if (bus.cmd_vld && bus.cmd_op == tpq_pkg::OP_CLR_EVT) begin
                evt_reg <= 1'b0;
            end
            if (fin_bad) begin
                evt_reg  <= 1'b1;
                fpnr_reg <= xpnr_reg;
            end
            if (fin) begin
                ph_reg <= stat_word;
            end
        end
    end

    // fifo port: failed number while the event stands, else head
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            port_reg       <= '0;
            port_empty_reg <= 1'b1;
        end else begin
            port_reg       <= evt_reg ? fpnr_reg : cq_head;
            port_empty_reg <= cq_empty && !evt_reg;
        end
    end

    assign bus.alloc_done = done_reg;
    assign bus.alloc_pnr  = apnr_reg;
    assign bus.rd_vld     = rd_vld_reg;
    assign bus.rd_data    = rd_data_reg;
    assign bus.tx_en      = tx_en_reg;
    assign bus.tx_int     = !cq_empty;
    assign bus.tx_evt     = evt_reg;
    assign bus.port_pnr   = port_reg;
    assign bus.port_empty = port_empty_reg;
    assign bus.ph_status  = ph_reg;
    assign o_mac_start    = start_reg;
    assign o_mac_pnr      = xpnr_reg;
    assign o_mac_rd_data  = mrd_reg;
endmodule

/* File: logic/tpq_host.sv */
`timescale 1ns/100ps
module tpq_host (
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rst_n,
    tpq_if.host                          bus,
    input  wire logic                    i_tx_vld,
    input  wire logic [tpq_pkg::DW-1:0]  i_tx_len,
    output logic                         o_tx_rdy,
    input  wire logic                    i_tx_wvld,
    input  wire logic [tpq_pkg::DW-1:0]  i_tx_word,
    output logic                         o_tx_wrdy,
    input  wire logic                    i_retry,
    output logic                         o_done_vld,
    output logic [tpq_pkg::PNR_W-1:0]    o_done_pnr,
    output logic [tpq_pkg::DW-1:0]       o_done_status
);
    localparam int DW = tpq_pkg::DW;

    tpq_pkg::tpq_hst_t             st_reg;
    tpq_pkg::tpq_hst_t             st_next;
    logic [DW-1:0]                 cnt_reg;
    logic [tpq_pkg::PNR_W-1:0]     pnr_reg;
    logic [DW-1:0]                 stat_reg;
    logic                          retry_reg;
    logic                          done_reg;

    // command issue and next state, one command per cycle
    always_comb begin
        st_next      = st_reg;
        bus.cmd_vld  = 1'b1;
        bus.cmd_op   = tpq_pkg::OP_NOP;
        bus.cmd_arg  = '0;
        o_tx_rdy     = 1'b0;
        o_tx_wrdy    = 1'b0;
        case (st_reg)
            tpq_pkg::H_INIT: begin
                bus.cmd_op  = tpq_pkg::OP_TX_EN;
                bus.cmd_arg = 16'h0001;
                st_next     = tpq_pkg::H_IDLE;
            end
            tpq_pkg::H_IDLE: begin
                o_tx_rdy = !bus.tx_evt && !bus.tx_int;
                if (bus.tx_evt) begin
                    st_next = tpq_pkg::H_FAIL;
                end else if (bus.tx_int) begin
                    st_next = tpq_pkg::H_SPNR;
                end else if (i_tx_vld) begin
                    bus.cmd_op  = tpq_pkg::OP_ALLOC;
                    bus.cmd_arg = i_tx_len;
                    st_next     = tpq_pkg::H_WAIT;
                end
            end
            tpq_pkg::H_WAIT: begin
                if (bus.alloc_done) begin
                    bus.cmd_op  = tpq_pkg::OP_SET_PNR;
                    bus.cmd_arg = DW'(bus.alloc_pnr);
                    st_next     = tpq_pkg::H_PTR;
                end
            end
            tpq_pkg::H_PTR: begin
                bus.cmd_op = tpq_pkg::OP_SET_PTR;
                st_next    = (cnt_reg == '0) ? tpq_pkg::H_ENQ
                                             : tpq_pkg::H_DATA;
            end
            tpq_pkg::H_DATA: begin
                o_tx_wrdy = 1'b1;
                if (i_tx_wvld) begin
                    bus.cmd_op  = tpq_pkg::OP_WR_DATA;
                    bus.cmd_arg = i_tx_word;
                    if (cnt_reg == 16'h0001) begin
                        st_next = tpq_pkg::H_ENQ;
                    end
                end
            end
            tpq_pkg::H_ENQ: begin
                bus.cmd_op = tpq_pkg::OP_ENQ;
                st_next    = tpq_pkg::H_IDLE;
            end
            tpq_pkg::H_SPNR: begin
                bus.cmd_op  = tpq_pkg::OP_SET_PNR;
                bus.cmd_arg = DW'(bus.port_pnr);
                st_next     = tpq_pkg::H_SPTR;
            end
            tpq_pkg::H_SPTR: begin
                bus.cmd_op = tpq_pkg::OP_SET_PTR;
                st_next    = tpq_pkg::H_SRD;
            end
            tpq_pkg::H_SRD: begin
                bus.cmd_op = tpq_pkg::OP_RD_DATA;
                st_next    = tpq_pkg::H_SWT;
            end
            tpq_pkg::H_SWT: begin
                if (bus.rd_vld) begin
                    st_next = tpq_pkg::H_SREL;
                end
            end
            tpq_pkg::H_SREL: begin
                if (stat_reg[tpq_pkg::ST_OK_BIT]) begin
                    bus.cmd_op  = tpq_pkg::OP_RELEASE;
                    bus.cmd_arg = DW'(pnr_reg);
                end
                st_next = tpq_pkg::H_SACK;
            end
            tpq_pkg::H_SACK: begin
                bus.cmd_op = tpq_pkg::OP_TX_ACK;
                st_next    = tpq_pkg::H_IDLE;
            end
            tpq_pkg::H_FAIL: begin
                bus.cmd_op  = tpq_pkg::OP_SET_PNR;
                bus.cmd_arg = DW'(bus.port_pnr);
                st_next     = tpq_pkg::H_FCLR;
            end
            // drop the event so the failure is handled only once
            tpq_pkg::H_FCLR: begin
                bus.cmd_op = tpq_pkg::OP_CLR_EVT;
                st_next    = tpq_pkg::H_FDEC;
            end
            tpq_pkg::H_FDEC: begin
                if (retry_reg) begin
                    bus.cmd_op  = tpq_pkg::OP_TX_EN;
                    bus.cmd_arg = 16'h0001;
                    st_next     = tpq_pkg::H_ENQ;
                end else begin
                    bus.cmd_op  = tpq_pkg::OP_RELEASE;
                    bus.cmd_arg = DW'(pnr_reg);
                    st_next     = tpq_pkg::H_IDLE;
                end
            end
            default: begin
                st_next = tpq_pkg::H_INIT;
            end
        endcase
    end

    // state, word count and captured service data
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            st_reg    <= tpq_pkg::H_INIT;
            cnt_reg   <= '0;
            pnr_reg   <= '0;
            stat_reg  <= '0;
            retry_reg <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            st_reg   <= st_next;
            done_reg <= 1'b0;
            if (st_reg == tpq_pkg::H_IDLE && st_next == tpq_pkg::H_WAIT) begin
                cnt_reg <= DW'((i_tx_len + 17'h00001) >> 1);
            end else if (bus.cmd_op == tpq_pkg::OP_WR_DATA) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
            if (st_reg == tpq_pkg::H_SPNR || st_reg == tpq_pkg::H_FAIL) begin
                pnr_reg <= bus.port_pnr;
            end
            if (st_reg == tpq_pkg::H_FAIL) begin
                stat_reg  <= bus.ph_status;
                retry_reg <= i_retry;
            end
            if (st_reg == tpq_pkg::H_SWT && bus.rd_vld) begin
                stat_reg <= bus.rd_data;
            end
            if (st_reg == tpq_pkg::H_SACK || st_reg == tpq_pkg::H_FDEC) begin
                done_reg <= 1'b1;
            end
        end
    end

    assign o_done_vld    = done_reg;
    assign o_done_pnr    = pnr_reg;
    assign o_done_status = stat_reg;
endmodule

/* File: dv/tpq_assertions.sv */
`timescale 1ns/100ps
module tpq_assertions (
    input wire logic                   i_clk_sys,
    input wire logic                   i_rst_n,
    input wire tpq_pkg::tpq_op_t       cmd_op,
    input wire logic [tpq_pkg::DW-1:0] cmd_arg,
    input wire logic                   alloc_done,
    input wire logic                   rd_vld,
    input wire logic                   tx_en,
    input wire logic                   tx_int,
    input wire logic                   tx_evt
);
    // every check runs on the system clock, idle in reset
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // allocation grant and flag lifetime
    property p_big; cmd_op == tpq_pkg::OP_ALLOC && cmd_arg > 16'h0080
        |=> !alloc_done; endproperty
    a_big: assert property (p_big) else $error("oversize alloc granted");
    property p_hold; alloc_done && cmd_op != tpq_pkg::OP_ALLOC
        |=> alloc_done; endproperty
    a_hold: assert property (p_hold) else $error("alloc flag lost");
    // buffer reads answer one cycle later, never unasked
    property p_rd; cmd_op == tpq_pkg::OP_RD_DATA |=> rd_vld; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_rdc; rd_vld |-> $past(cmd_op) == tpq_pkg::OP_RD_DATA;
    endproperty
    a_rdc: assert property (p_rdc) else $error("read data unasked");
    // failure drops enable and the event stands until cleared
    property p_evt; $rose(tx_evt) |-> !tx_en; endproperty
    a_evt: assert property (p_evt) else $error("enable kept on fail");
    property p_evh; tx_evt && cmd_op != tpq_pkg::OP_CLR_EVT
        |=> tx_evt; endproperty
    a_evh: assert property (p_evh) else $error("event dropped");
    property p_ena; $rose(tx_en) |-> $past(cmd_op) == tpq_pkg::OP_TX_EN;
    endproperty
    a_ena: assert property (p_ena) else $error("enable unasked");
    // completion entries leave only on acknowledge
    property p_int; tx_int && cmd_op != tpq_pkg::OP_TX_ACK
        |=> tx_int; endproperty
    a_int: assert property (p_int) else $error("tx int lost");
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    logic                   i_clk_sys = 1'b0;
    logic                   i_rst_n   = 1'b0;
    logic                   hd = 1'b0, dok = 1'b0, tvld = 1'b0;
    logic                   wvld = 1'b0, retry = 1'b1, mdone = 1'b0;
    logic                   mok = 1'b0, trdy, twrdy, dv, mstart;
    logic [tpq_pkg::DW-1:0] len = 16'h0000, word = 16'h0000;
    logic [tpq_pkg::DW-1:0] mst = 16'hc3a4, mrd, dstat;
    logic [5:0]             radr = 6'h00;
    logic [2:0]             dpnr, mpnr;
    int                     error_cnt = 0, checks = 0, cyc = 0;

    // system clock
    always #4 i_clk_sys = ~i_clk_sys;

    tpq_if bus ();
    tpq_dev tpq_dev_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .bus(bus), .i_auto_release(1'b0), .i_half_duplex(hd),
        .i_defer_ok(dok), .o_mac_start(mstart), .o_mac_pnr(mpnr),
        .i_mac_rd_addr(radr), .o_mac_rd_data(mrd), .i_mac_done(mdone),
        .i_mac_ok(mok), .i_mac_status(mst));
    tpq_host tpq_host_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .bus(bus), .i_tx_vld(tvld), .i_tx_len(len), .o_tx_rdy(trdy),
        .i_tx_wvld(wvld), .i_tx_word(word), .o_tx_wrdy(twrdy),
        .i_retry(retry), .o_done_vld(dv), .o_done_pnr(dpnr),
        .o_done_status(dstat));
    tpq_assertions tpq_assertions_inst (.i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n), .cmd_op(bus.cmd_op), .cmd_arg(bus.cmd_arg),
        .alloc_done(bus.alloc_done), .rd_vld(bus.rd_vld),
        .tx_en(bus.tx_en), .tx_int(bus.tx_int), .tx_evt(bus.tx_evt));

    task automatic close_out();
        if (error_cnt == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask

    // bounded wait for a flag, sampled at the falling edge
    task automatic wt(ref logic s);
        int n;
        n = 0;
        do begin
            @(negedge i_clk_sys);
            n++;
        end while (s !== 1'b1 && n < 300);
        cmp({15'h0, s}, 16'h0001);
    endtask

    // one packet: nf failed attempts before success, h = half duplex
    task automatic send(input logic [15:0] l, input logic [15:0] w,
                        input int nf, input logic h, input logic [2:0] ep);
        int k;
        @(posedge i_clk_sys);
        hd <= h;
        dok <= !h;
        tvld <= 1'b1;
        len <= l;
        wt(trdy);
        @(posedge i_clk_sys);
        tvld <= 1'b0;
        wvld <= 1'b1;
        word <= w;
        for (k = 1; k <= (l + 1) / 2; k++) begin
            wt(twrdy);
            @(posedge i_clk_sys);
            word <= w + 16'(k);
            wvld <= (k < (l + 1) / 2);
        end
        if (h) begin
            repeat (30) begin
                @(negedge i_clk_sys);
                cmp({15'h0, mstart}, 16'h0000);
            end
            @(posedge i_clk_sys);
            dok <= 1'b1;
        end
        for (k = 0; k <= nf; k++) begin
            wt(mstart);
            cmp({13'h0, mpnr}, {13'h0, ep});
            @(posedge i_clk_sys);
            radr <= 6'h01;
            @(posedge i_clk_sys);
            @(negedge i_clk_sys);
            cmp(mrd, w + 16'h0001);
            @(posedge i_clk_sys);
            mok <= (k == nf);
            mdone <= 1'b1;
            @(posedge i_clk_sys);
            mdone <= 1'b0;
        end
        wt(dv);
        cmp({13'h0, dpnr}, {13'h0, ep});
        cmp(dstat, {mst[15:1], 1'b1});
    endtask

    // second reset, then a request larger than a packet buffer
    task automatic t_big();
        @(posedge i_clk_sys);
        i_rst_n <= 1'b0;
        tvld <= 1'b1;
        len <= 16'h0081;
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        repeat (20) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        cmp({15'h0, bus.alloc_done}, 16'h0000);
        cmp({15'h0, bus.port_empty}, 16'h0001);
        cmp({15'h0, bus.tx_en}, 16'h0001);
    endtask

    // cycle ceiling against hangs
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            close_out();
        end
    end

    // main sequence
    initial begin
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        send(16'h0005, 16'h1100, 0, 1'b0, 3'h0);
        send(16'h0080, 16'h2200, 0, 1'b0, 3'h0);
        send(16'h0004, 16'h3300, 0, 1'b1, 3'h0);
        send(16'h0006, 16'h4400, 2, 1'b0, 3'h0);
        t_big();
        close_out();
    end
endmodule
